/* File: hw/cft_tab_control.sv */
// Operation
// - In direct mode a forward tab steps the cursor right once and stops, with no search.
// - In direct mode a backward tab request is ignored and the cursor stays put.
// - In buffered mode a horizontal tab sets the in-progress state and starts the search.
// - The tab-busy indication is raised for the whole of a forward or backward search.
// - The cursor-blank signal is raised while the cursor registers are stepped by a search.
// - A forward search raises move-right so the column steps by one on each execute slot short of line end.
// - A protected field code or an ordinary character keeps the forward search stepping; the code aborts once step_count reaches limit.
// - At line end with no code found, column clears and row steps down once; search goes on.
// - On an unprotected field code the forward search steps right once more and halts.
// - A forward tab ends with busy and blank low and cursor one past the unprotected code.
// - A backtab starts a backward search, of use only with field codes in memory.
// - A backtab leaves the cursor on the first position of the preceding unprotected field.
// - A backtab skips the code of the field now holding the cursor, protected or not.
// - A backtab steps left, and up at line starts, until an unprotected code, then stops; the code also aborts once step_count reaches limit.
// - After a backward search halts on an unprotected code, the column steps right once.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "cft_cfg.svh"

module cft_tab_control (
    input  wire logic                  CLOCK_IN,
    input  wire logic                  RESET_IN,
    input  wire logic                  CE_IN,
    input  wire cft_pkg::cft_axi_req_t AXI_REQ_IN,
    output cft_pkg::cft_axi_rsp_t      AXI_RSP_OUT,
    input  wire logic                  BUFFER_MODE_IN,
    input  wire logic                  TAB_REQ_IN,
    input  wire logic                  BACKTAB_REQ_IN,
    input  wire logic                  EXECUTE_SLOT_IN,
    input  wire cft_pkg::cft_char_t    CHAR_IN,
    output cft_pkg::cft_step_t         STEP_OUT,
    output logic                       TAB_IN_PROGRESS_OUT,
    output logic                       CURSOR_BLANK_HOLD_OUT
);
    import cft_pkg::*;

    // ======================================================================
    // state and reset image
    // ======================================================================
    localparam cft_core_t CORE_RST = '{
        mode    : ST_IDLE,
        enable  : `CFT_ENABLE_RST,
        limit   : `CFT_LIMIT_RST,
        default : '0
    };

    cft_core_t   core_reg;
    cft_core_t   core_next;
    logic        pin_buffered;
    logic        buffered;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        wr_hit;
    logic        limit_hit;

    // ======================================================================
    // switch input and register bus
    // ======================================================================
    cft_sync2 u_mode_sync (
        .CLOCK_IN (CLOCK_IN),
        .RESET_IN (RESET_IN),
        .CE_IN    (CE_IN),
        .d_in     (BUFFER_MODE_IN),
        .q_out    (pin_buffered)
    );

    cft_axil_slave u_bus (
        .CLOCK_IN    (CLOCK_IN),
        .RESET_IN    (RESET_IN),
        .CE_IN       (CE_IN),
        .req_in      (AXI_REQ_IN),
        .rsp_out     (AXI_RSP_OUT),
        .wr_en_out   (wr_en),
        .wr_addr_out (wr_addr),
        .wr_data_out (wr_data),
        .wr_strb_out (wr_strb),
        .rd_addr_out (rd_addr),
        .rd_data_in  (rd_data),
        .rd_hit_in   (rd_hit),
        .wr_hit_in   (wr_hit)
    );

    assign buffered  = core_reg.sw_sel ? core_reg.sw_buffered : pin_buffered;
    assign limit_hit = (core_reg.step_count >= core_reg.limit);
    assign wr_hit    = (wr_addr == `CFT_ADDR_CTRL) || (wr_addr == `CFT_ADDR_LIMIT)
                    || (wr_addr == `CFT_ADDR_STATUS) || (wr_addr == `CFT_ADDR_COUNT);

    // ======================================================================
    // read mux
    // ======================================================================
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (rd_addr)
            `CFT_ADDR_CTRL:
            begin
                rd_data[`CFT_CTRL_ENABLE] = core_reg.enable;
                rd_data[`CFT_CTRL_SW_SEL] = core_reg.sw_sel;
                rd_data[`CFT_CTRL_SW_BUF] = core_reg.sw_buffered;
            end
            `CFT_ADDR_LIMIT:
                rd_data[15:0] = core_reg.limit;
            `CFT_ADDR_STATUS:
            begin
                rd_data[`CFT_STAT_BUSY]     = core_reg.busy;
                rd_data[`CFT_STAT_BACKWARD] = core_reg.backward;
                rd_data[`CFT_STAT_ABORTED]  = core_reg.aborted;
                rd_data[`CFT_STAT_BUFFERED] = buffered;
            end
            `CFT_ADDR_COUNT:
                rd_data[15:0] = core_reg.tab_count;
            default:
                rd_hit = 1'b0;
        endcase
    end

    // ======================================================================
    // tab sequencer and register writes
    // ======================================================================
    always_comb
    begin
        core_next       = core_reg;
        core_next.steps = '0;

        if (wr_en)
        begin
            if (wr_addr == `CFT_ADDR_CTRL && wr_strb[0])
            begin
                core_next.enable      = wr_data[`CFT_CTRL_ENABLE];
                core_next.sw_sel      = wr_data[`CFT_CTRL_SW_SEL];
                core_next.sw_buffered = wr_data[`CFT_CTRL_SW_BUF];
            end
            if (wr_addr == `CFT_ADDR_LIMIT)
            begin
                if (wr_strb[0])
                    core_next.limit[7:0] = wr_data[7:0];
                if (wr_strb[1])
                    core_next.limit[15:8] = wr_data[15:8];
            end
            // writing a one to the status abort bit clears the sticky abort mark
            if (wr_addr == `CFT_ADDR_STATUS && wr_strb[0] && wr_data[`CFT_STAT_ABORTED])
                core_next.aborted = 1'b0;
        end

        case (core_reg.mode)
            ST_IDLE:
            begin
                if (core_reg.enable && TAB_REQ_IN)
                begin
                    core_next.step_count = 16'h0000;
                    core_next.backward   = 1'b0;
                    if (buffered)
                    begin
                        core_next.mode  = ST_FWD_LEAVE;
                        core_next.busy  = 1'b1;
                        core_next.blank = 1'b1;
                    end
                    else
                        core_next.mode = ST_SPACE;
                end
                else if (core_reg.enable && BACKTAB_REQ_IN && buffered)
                begin
                    core_next.mode        = ST_BWD_LEAVE;
                    core_next.step_count  = 16'h0000;
                    core_next.backward    = 1'b1;
                    core_next.fac_skipped = 1'b0;
                    core_next.busy        = 1'b1;
                    core_next.blank       = 1'b1;
                end
            end

            ST_SPACE:
            begin
                if (EXECUTE_SLOT_IN)
                begin
                    core_next.steps.move_right = 1'b1;
                    core_next.mode             = ST_IDLE;
                end
            end

            ST_FWD_LEAVE:
            begin
                if (EXECUTE_SLOT_IN)
                begin
                    core_next.steps.move_right = 1'b1;
                    core_next.step_count       = core_reg.step_count + 16'h0001;
                    core_next.mode             = ST_FWD_SCAN;
                end
            end

            ST_FWD_SCAN:
            begin
                if (EXECUTE_SLOT_IN)
                begin
                    core_next.step_count = core_reg.step_count + 16'h0001;
                    if (CHAR_IN.is_fac && !CHAR_IN.fac_protected)
                    begin
                        core_next.steps.move_right = 1'b1;
                        core_next.mode             = ST_IDLE;
                        core_next.busy             = 1'b0;
                        core_next.blank            = 1'b0;
                        core_next.tab_count        = core_reg.tab_count + 16'h0001;
                    end
                    else if (limit_hit)
                    begin
                        core_next.mode    = ST_IDLE;
                        core_next.busy    = 1'b0;
                        core_next.blank   = 1'b0;
                        core_next.aborted = 1'b1;
                    end
                    else if (CHAR_IN.column_at_end)
                    begin
                        core_next.steps.column_register_clear = 1'b1;
                        core_next.steps.move_down             = 1'b1;
                    end
                    else
                        core_next.steps.move_right = 1'b1;
                end
            end

            ST_BWD_LEAVE:
            begin
                if (EXECUTE_SLOT_IN)
                begin
                    core_next.steps.move_left = 1'b1;
                    core_next.steps.move_up   = CHAR_IN.column_at_start;
                    core_next.step_count      = core_reg.step_count + 16'h0001;
                    core_next.mode            = ST_BWD_SCAN;
                end
            end

            ST_BWD_SCAN:
            begin
                if (EXECUTE_SLOT_IN)
                begin
                    core_next.step_count = core_reg.step_count + 16'h0001;
                    if (CHAR_IN.is_fac && !core_reg.fac_skipped)
                    begin
                        // own field's code passed over
                        core_next.fac_skipped     = 1'b1;
                        core_next.steps.move_left = 1'b1;
                        core_next.steps.move_up   = CHAR_IN.column_at_start;
                    end
                    else if (CHAR_IN.is_fac && !CHAR_IN.fac_protected)
                    begin
                        core_next.steps.move_right = 1'b1;
                        core_next.mode             = ST_IDLE;
                        core_next.busy             = 1'b0;
                        core_next.blank            = 1'b0;
                        core_next.tab_count        = core_reg.tab_count + 16'h0001;
                    end
                    else if (limit_hit)
                    begin
                        core_next.mode    = ST_IDLE;
                        core_next.busy    = 1'b0;
                        core_next.blank   = 1'b0;
                        core_next.aborted = 1'b1;
                    end
                    else
                    begin
                        core_next.steps.move_left = 1'b1;
                        core_next.steps.move_up   = CHAR_IN.column_at_start;
                    end
                end
            end

            default:
            begin
                core_next.mode  = ST_IDLE;
                core_next.busy  = 1'b0;
                core_next.blank = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // state register
    // ======================================================================
    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
            core_reg <= CORE_RST;
        else if (CE_IN)
            core_reg <= core_next;
    end

    assign STEP_OUT              = core_reg.steps;
    assign TAB_IN_PROGRESS_OUT   = core_reg.busy;
    assign CURSOR_BLANK_HOLD_OUT = core_reg.blank;

endmodule : cft_tab_control

/* File: hw/cft_cfg.svh */
`ifndef CFT_CFG_SVH
`define CFT_CFG_SVH

// ==========================================================================
// register map
// ==========================================================================
`define CFT_ADDR_W          8
`define CFT_ADDR_CTRL       8'h00
`define CFT_ADDR_LIMIT      8'h04
`define CFT_ADDR_STATUS     8'h08
`define CFT_ADDR_COUNT      8'h0C

// ==========================================================================
// field positions
// ==========================================================================
`define CFT_CTRL_ENABLE     0
`define CFT_CTRL_SW_SEL     1
`define CFT_CTRL_SW_BUF     2
`define CFT_STAT_BUSY       0
`define CFT_STAT_BACKWARD   1
`define CFT_STAT_ABORTED    2
`define CFT_STAT_BUFFERED   3

// ==========================================================================
// reset values and responses
// ==========================================================================
`define CFT_ENABLE_RST      1'h1
`define CFT_LIMIT_RST       16'h0FFF
`define CFT_RESP_OKAY       2'h0
`define CFT_RESP_DECERR     2'h3

`endif

/* File: hw/cft_pkg.sv */
package cft_pkg;

    // ======================================================================
    // sequencer states
    // ======================================================================
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_SPACE     = 3'b001,
        ST_FWD_LEAVE = 3'b010,
        ST_FWD_SCAN  = 3'b011,
        ST_BWD_LEAVE = 3'b100,
        ST_BWD_SCAN  = 3'b101
    } cft_mode_t;

    // ======================================================================
    // bus carriers
    // ======================================================================
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } cft_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cft_axi_rsp_t;

    // ======================================================================
    // cursor side carriers
    // ======================================================================
    typedef struct packed {
        logic is_fac;
        logic fac_protected;
        logic column_at_end;
        logic column_at_start;
    } cft_char_t;

    typedef struct packed {
        logic move_right;
        logic move_left;
        logic move_down;
        logic move_up;
        logic column_register_clear;
    } cft_step_t;

    // ======================================================================
    // module state records
    // ======================================================================
    typedef struct packed {
        logic [1:0] stage;
    } cft_sync_t;

    typedef struct packed {
        cft_axi_rsp_t rsp;
        logic         aw_held;
        logic         w_held;
        logic         rd_pend;
        logic [7:0]   waddr;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic [7:0]   raddr;
        logic         wr_en;
    } cft_bus_t;

    typedef struct packed {
        cft_mode_t   mode;
        cft_step_t   steps;
        logic        busy;
        logic        blank;
        logic        backward;
        logic        fac_skipped;
        logic        aborted;
        logic [15:0] step_count;
        logic [15:0] tab_count;
        logic        enable;
        logic        sw_sel;
        logic        sw_buffered;
        logic [15:0] limit;
    } cft_core_t;

endpackage : cft_pkg

/* File: hw/cft_sync2.sv */
`timescale 1ns/1ps

module cft_sync2 (
    input  wire logic CLOCK_IN,
    input  wire logic RESET_IN,
    input  wire logic CE_IN,
    input  wire logic d_in,
    output logic      q_out
);
    import cft_pkg::*;

    cft_sync_t s_reg;
    cft_sync_t s_next;

    always_comb
    begin
        s_next.stage = {s_reg.stage[0], d_in};
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
            s_reg <= '0;
        else if (CE_IN)
            s_reg <= s_next;
    end

    assign q_out = s_reg.stage[1];

endmodule : cft_sync2

/* File: hw/cft_axil_slave.sv */
`timescale 1ns/1ps
`include "cft_cfg.svh"

module cft_axil_slave (
    input  wire logic                 CLOCK_IN,
    input  wire logic                 RESET_IN,
    input  wire logic                 CE_IN,
    input  wire cft_pkg::cft_axi_req_t req_in,
    output cft_pkg::cft_axi_rsp_t     rsp_out,
    output logic                      wr_en_out,
    output logic [7:0]                wr_addr_out,
    output logic [31:0]               wr_data_out,
    output logic [3:0]                wr_strb_out,
    output logic [7:0]                rd_addr_out,
    input  wire logic [31:0]          rd_data_in,
    input  wire logic                 rd_hit_in,
    input  wire logic                 wr_hit_in
);
    import cft_pkg::*;

    cft_bus_t b_reg;
    cft_bus_t b_next;

    always_comb
    begin
        b_next       = b_reg;
        b_next.wr_en = 1'b0;
        // ==================================================================
        // write side: address and data in either order
        // ==================================================================
        if (req_in.awvalid && b_reg.rsp.awready)
        begin
            b_next.aw_held     = 1'b1;
            b_next.waddr       = req_in.awaddr;
            b_next.rsp.awready = 1'b0;
        end
        if (req_in.wvalid && b_reg.rsp.wready)
        begin
            b_next.w_held     = 1'b1;
            b_next.wdata      = req_in.wdata;
            b_next.wstrb      = req_in.wstrb;
            b_next.rsp.wready = 1'b0;
        end
        if (b_reg.aw_held && b_reg.w_held && !b_reg.rsp.bvalid)
        begin
            b_next.wr_en      = 1'b1;
            b_next.aw_held    = 1'b0;
            b_next.w_held     = 1'b0;
            b_next.rsp.bvalid = 1'b1;
            b_next.rsp.bresp  = wr_hit_in ? `CFT_RESP_OKAY : `CFT_RESP_DECERR;
        end
        if (b_reg.rsp.bvalid && req_in.bready)
        begin
            b_next.rsp.bvalid  = 1'b0;
            b_next.rsp.awready = 1'b1;
            b_next.rsp.wready  = 1'b1;
        end
        // ==================================================================
        // read side
        // ==================================================================
        if (req_in.arvalid && b_reg.rsp.arready)
        begin
            b_next.raddr       = req_in.araddr;
            b_next.rd_pend     = 1'b1;
            b_next.rsp.arready = 1'b0;
        end
        if (b_reg.rd_pend)
        begin
            b_next.rd_pend    = 1'b0;
            b_next.rsp.rvalid = 1'b1;
            b_next.rsp.rdata  = rd_data_in;
            b_next.rsp.rresp  = rd_hit_in ? `CFT_RESP_OKAY : `CFT_RESP_DECERR;
        end
        if (b_reg.rsp.rvalid && req_in.rready)
        begin
            b_next.rsp.rvalid  = 1'b0;
            b_next.rsp.arready = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
            b_reg <= '{rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
                       default: '0};
        else if (CE_IN)
            b_reg <= b_next;
    end

    assign rsp_out     = b_reg.rsp;
    assign wr_en_out   = b_reg.wr_en;
    assign wr_addr_out = b_reg.waddr;
    assign wr_data_out = b_reg.wdata;
    assign wr_strb_out = b_reg.wstrb;
    assign rd_addr_out = b_reg.raddr;

endmodule : cft_axil_slave

/* File: sim/cft_tab_sva.sv */
`timescale 1ns/1ps

module cft_tab_sva (
    input wire logic               CLOCK_IN,
    input wire logic               RESET_IN,
    input wire logic               CE_IN,
    input wire logic               BUFFER_MODE_IN,
    input wire logic               TAB_REQ_IN,
    input wire logic               BACKTAB_REQ_IN,
    input wire logic               EXECUTE_SLOT_IN,
    input wire cft_pkg::cft_char_t CHAR_IN,
    input wire cft_pkg::cft_step_t STEP_OUT,
    input wire logic               TAB_IN_PROGRESS_OUT,
    input wire logic               CURSOR_BLANK_HOLD_OUT
);
    import cft_pkg::*;

    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN || !CE_IN);

    // ==========================================================
    // search start and end
    sequence s_buf_req;
        BUFFER_MODE_IN [*4] ##0 ((TAB_REQ_IN || BACKTAB_REQ_IN) && !TAB_IN_PROGRESS_OUT);
    endsequence
    sequence s_end;
        $fell(TAB_IN_PROGRESS_OUT) && STEP_OUT.move_right;
    endsequence

    a_step_after_exec: assert property (|STEP_OUT |-> $past(EXECUTE_SLOT_IN))
        else $error("step pulse without execute slot");
    a_busy_blank: assert property (TAB_IN_PROGRESS_OUT == CURSOR_BLANK_HOLD_OUT)
        else $error("busy and blank differ");
    a_search_starts: assert property (s_buf_req |=> TAB_IN_PROGRESS_OUT)
        else $error("search did not start");
    a_direct_quiet: assert property (!BUFFER_MODE_IN [*4] ##0 !TAB_IN_PROGRESS_OUT
        |=> !TAB_IN_PROGRESS_OUT)
        else $error("busy raised in direct mode");
    a_left_in_search: assert property (STEP_OUT.move_left || STEP_OUT.move_up
        |-> TAB_IN_PROGRESS_OUT)
        else $error("left or up step outside a search");
    a_wrap_up: assert property (STEP_OUT.move_left
        |-> STEP_OUT.move_up == $past(CHAR_IN.column_at_start))
        else $error("up step not tied to line start");
    a_line_end: assert property (STEP_OUT.column_register_clear |-> STEP_OUT.move_down
        && !STEP_OUT.move_right && $past(CHAR_IN.column_at_end))
        else $error("bad line end step");
    a_keep_stepping: assert property (TAB_IN_PROGRESS_OUT && EXECUTE_SLOT_IN
        && !(CHAR_IN.is_fac && !CHAR_IN.fac_protected)
        |=> TAB_IN_PROGRESS_OUT && (|STEP_OUT))
        else $error("search stopped early");
    a_end_on_fac: assert property (s_end |-> STEP_OUT == 5'h10
        && $past(CHAR_IN.is_fac) && !$past(CHAR_IN.fac_protected))
        else $error("search ended off an unprotected code");
endmodule : cft_tab_sva

bind cft_tab_control cft_tab_sva u_sva (.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN),
    .CE_IN(CE_IN), .BUFFER_MODE_IN(BUFFER_MODE_IN), .TAB_REQ_IN(TAB_REQ_IN),
    .BACKTAB_REQ_IN(BACKTAB_REQ_IN), .EXECUTE_SLOT_IN(EXECUTE_SLOT_IN), .CHAR_IN(CHAR_IN),
    .STEP_OUT(STEP_OUT), .TAB_IN_PROGRESS_OUT(TAB_IN_PROGRESS_OUT),
    .CURSOR_BLANK_HOLD_OUT(CURSOR_BLANK_HOLD_OUT));

/* File: sim/cft_cursor_model.sv */
`timescale 1ns/1ps

module cft_cursor_model (
    input  wire logic               clock_in,
    input  wire logic               reset_in,
    input  wire cft_pkg::cft_step_t step_in,
    input  wire logic [31:0]        fac_map_in,
    input  wire logic [31:0]        prot_map_in,
    output logic                    exec_out,
    output cft_pkg::cft_char_t      char_out,
    output logic [2:0]              col_out,
    output logic [1:0]              row_out
);
    import cft_pkg::*;
    logic [1:0] slot_reg;

    // ==========================================================
    // execute slot every third cycle, 8 x 4 screen
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            slot_reg <= 2'h0;
            exec_out <= 1'b0;
            col_out  <= 3'h0;
            row_out  <= 2'h0;
        end
        else
        begin
            slot_reg <= (slot_reg == 2'h2) ? 2'h0 : slot_reg + 2'h1;
            exec_out <= (slot_reg == 2'h2);
            if (step_in.column_register_clear)
                col_out <= 3'h0;
            else if (step_in.move_right)
                col_out <= col_out + 3'h1;
            else if (step_in.move_left)
                col_out <= col_out - 3'h1;
            if (step_in.move_down)
                row_out <= row_out + 2'h1;
            else if (step_in.move_up)
                row_out <= row_out - 2'h1;
        end
    end

    assign char_out = {fac_map_in[{row_out, col_out}], prot_map_in[{row_out, col_out}],
                       col_out == 3'h7, col_out == 3'h0};
endmodule : cft_cursor_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    import cft_pkg::*;
    logic         clk, rst, buf_mode, tab_req, back_req, execute, busy, blank;
    logic [31:0]  rdata;
    logic [1:0]   resp, row;
    logic [2:0]   col;
    int           mismatches, checks, cycles = 0;
    cft_axi_req_t req;
    cft_axi_rsp_t rsp;
    cft_char_t    chr;
    cft_step_t    step;

    always #4 clk = ~clk;

    cft_tab_control DUT (.CLOCK_IN(clk), .RESET_IN(rst), .CE_IN(1'b1), .AXI_REQ_IN(req),
        .AXI_RSP_OUT(rsp), .BUFFER_MODE_IN(buf_mode), .TAB_REQ_IN(tab_req),
        .BACKTAB_REQ_IN(back_req), .EXECUTE_SLOT_IN(execute), .CHAR_IN(chr),
        .STEP_OUT(step), .TAB_IN_PROGRESS_OUT(busy), .CURSOR_BLANK_HOLD_OUT(blank));
    cft_cursor_model u_far (.clock_in(clk), .reset_in(rst), .step_in(step),
        .fac_map_in(32'h0000_0428), .prot_map_in(32'h0000_0008), .exec_out(execute),
        .char_out(chr), .col_out(col), .row_out(row));

    task automatic summarize;
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rdata = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic search(input logic bm, input logic back, input logic [2:0] c,
                          input logic [1:0] r);
        if (back)
            back_req <= 1'b1;
        else
            tab_req <= 1'b1;
        @(posedge clk);
        tab_req  <= 1'b0;
        back_req <= 1'b0;
        @(posedge clk);
        chk(busy === bm && blank === bm, "busy or blank wrong");
        while (busy === 1'b1) @(posedge clk);
        repeat (6) @(posedge clk);
        chk(col === c && row === r, "cursor misplaced");
    endtask : search

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        buf_mode = 1'b0;
        tab_req = 1'b0;
        back_req = 1'b0;
        req = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00);
        chk(rdata === 32'h0000_0001 && resp === 2'h0, "ctrl reset value");
        rd(8'h04);
        chk(rdata === 32'h0000_0FFF, "limit reset value");
        wr(8'h04, 32'h0000_0100);
        chk(resp === 2'h0, "write response");
        rd(8'h04);
        chk(rdata === 32'h0000_0100, "limit readback");
        rd(8'h10);
        chk(resp === 2'h3 && rdata === 32'h0, "unmapped read");
        wr(8'h10, 32'h0000_0000);
        chk(resp === 2'h3, "unmapped write");
        search(1'b0, 1'b0, 3'h1, 2'h0);
        search(1'b0, 1'b1, 3'h1, 2'h0);
        buf_mode <= 1'b1;
        repeat (4) @(posedge clk);
        search(1'b1, 1'b0, 3'h6, 2'h0);
        search(1'b1, 1'b0, 3'h3, 2'h1);
        search(1'b1, 1'b1, 3'h6, 2'h0);
        rd(8'h08);
        chk(rdata === 32'h0000_000A, "status after backtab");
        rd(8'h0C);
        chk(rdata === 32'h0000_0003, "search count");
        summarize();
    end
endmodule : tb_top
